// ==== src/lcdrf_top.sv ====
// LCD refresh engine: display buffer, AXI4-Lite registers and serial panel interface
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lcdrf_consts.svh"

module lcdrf_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        lcd_clk_src,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             ac_alternate_out,
  output logic             dot_clock_out,
  output logic             line_pulse_out,
  output logic             first_line_marker_out,
  output logic [3:0]       panel_data_out,
  output logic             lcd_pin_select
);

  lcdrf_pkg::lcdrf_regs_t q;            // Registered state
  lcdrf_pkg::lcdrf_regs_t d;            // Next state
  logic [15:0]            buf_mem [4096]; // Display buffer
  logic                   tick;         // One aclk pulse per LCD clock rise
  logic                   mem_we;
  logic [11:0]            mem_idx;
  logic [15:0]            mem_wd;
  logic [15:0]            mem_old;      // Word under the pending write
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic [15:0]            fifo_in_data;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [15:0]            fifo_out_data;
  logic                   pix_on;       // Current pixel after modulation
  logic [1:0]             ppd_last;     // Pixels per dot minus one

  // every panel step from ST_HOLD to ST_LINE_END waits for an LCD clock rise seen by the synchroniser; ST_GATHER runs on aclk
  assign tick = (q.sync[1] == q.sync[2]) && q.sync[2] && !q.dot_clock_out_stable;

  // Outputs come straight from the state register
  assign ac_alternate_out      = q.ac;
  assign dot_clock_out         = q.dot;
  assign line_pulse_out        = q.lp;
  assign first_line_marker_out = q.fp;
  assign panel_data_out        = q.data;
  assign lcd_pin_select        = q.pin_sel;
  assign s_axi_awready         = q.awready;
  assign s_axi_wready          = q.wready;
  assign s_axi_bresp           = q.bresp;
  assign s_axi_bvalid          = q.bvalid;
  assign s_axi_arready         = q.arready;
  assign s_axi_rdata           = q.rdata;
  assign s_axi_rresp           = q.rresp;
  assign s_axi_rvalid          = q.rvalid;

  // fetch reads only buffer words, stopping after the last one
  assign fifo_in_valid = q.en && !q.fetch_done && !q.flush
                         && (q.st != lcdrf_pkg::ST_IDLE);
  assign fifo_in_data  = buf_mem[q.fa[11:0]];
  assign mem_old       = buf_mem[q.awaddr[13:2]];
  assign ppd_last      = q.four_bit ? `LCDRF_PPD_FOUR : `LCDRF_PPD_ONE;

  // level 3 always on, 2 on two frames of three, 1 on one of three
  always_comb
  begin
    pix_on = 1'b0;
    if (q.grey)
    begin
      unique case (q.sh[1:0])
        2'h3: pix_on = 1'b1;
        2'h2: pix_on = (q.frm != `LCDRF_FRM_LAST);
        2'h1: pix_on = (q.frm == 2'h0);
        2'h0: pix_on = 1'b0;
      endcase
    end
    else
      // one bit per pixel, lowest bit first
      pix_on = q.sh[0];
  end

  // Words from the buffer, 8 deep; a stalled shifter stops the fetch
  lcdrf_fifo #(
    .WIDTH (16),
    .DEPTH (8)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (q.flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Next-state logic: bus slave, fetch and panel sequencer
  always_comb
  begin
    d              = q;
    mem_we         = 1'b0;
    mem_idx        = q.awaddr[13:2];
    mem_wd         = mem_old;
    fifo_out_ready = 1'b0;
    d.flush        = 1'b0;

    // Three-stage synchroniser on the LCD clock pin
    d.sync = {q.sync[1:0], lcd_clk_src};
    if (q.sync[1] == q.sync[2])
      d.dot_clock_out_stable = q.sync[2];

    // Write address and data are taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.awaddr  = s_axi_awaddr;
      d.aw_held = 1'b1;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
      d.w_held = 1'b1;
      d.wready = 1'b0;
    end

    // Both halves present: perform the write and raise the response
    if (q.aw_held && q.w_held && !q.bvalid)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `LCDRF_RESP_OKAY;
      if (q.awaddr[17:14] == `LCDRF_BUF_SEL)
      begin
        // software writes pattern words, lanes 0 and 1 only
        mem_we = q.wstrb[0] || q.wstrb[1];
        mem_wd = {q.wstrb[1] ? q.wdata[15:8] : mem_old[15:8],
                  q.wstrb[0] ? q.wdata[7:0]  : mem_old[7:0]};
      end
      else
      begin
        unique case (q.awaddr)
          `LCDRF_CTRL_OFF:
          begin
            if (q.wstrb[0])
            begin
              d.en       = q.wdata[`LCDRF_CTRL_EN];
              d.four_bit = q.wdata[`LCDRF_CTRL_FOUR];
              d.grey     = q.wdata[`LCDRF_CTRL_GREY];
              // pin function hands the port pins to the panel signals
              d.pin_sel  = q.wdata[`LCDRF_CTRL_PINS];
            end
          end
          `LCDRF_START_OFF:
          begin
            if (q.wstrb[0])
              d.start[7:0] = q.wdata[7:0];
            if (q.wstrb[1])
              d.start[15:8] = q.wdata[15:8];
          end
          `LCDRF_SEGS_OFF:
          begin
            if (q.wstrb[0])
              d.segs[7:0] = q.wdata[7:0];
            if (q.wstrb[1])
              d.segs[8] = q.wdata[8];
          end
          `LCDRF_COMS_OFF:
          begin
            if (q.wstrb[0])
              d.coms = q.wdata[7:0];
          end
          `LCDRF_STATUS_OFF: d.bresp = `LCDRF_RESP_OKAY;
          default:           d.bresp = `LCDRF_RESP_SLVERR;
        endcase
      end
    end
    // Response accepted: reopen both write channels
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // Read: answer one cycle after the address is taken
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = `LCDRF_RESP_OKAY;
      d.rdata   = 32'h00000000;
      if (s_axi_araddr[17:14] == `LCDRF_BUF_SEL)
        d.rdata = {16'h0000, buf_mem[s_axi_araddr[13:2]]};
      else
      begin
        unique case (s_axi_araddr)
          `LCDRF_CTRL_OFF:   d.rdata = {28'h0000000, q.pin_sel, q.grey, q.four_bit, q.en};
          `LCDRF_START_OFF:  d.rdata = {16'h0000, q.start};
          `LCDRF_SEGS_OFF:   d.rdata = {23'h000000, q.segs};
          `LCDRF_COMS_OFF:   d.rdata = {24'h000000, q.coms};
          `LCDRF_STATUS_OFF: d.rdata = {q.frames, q.line, 7'h00, (q.st != lcdrf_pkg::ST_IDLE)};
          default:           d.rresp = `LCDRF_RESP_SLVERR;
        endcase
      end
    end
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // Fetch pointer advances on each word the FIFO accepts except the last buffer word, which ends the fetch
    if (fifo_in_valid && fifo_in_ready)
    begin
      if (q.fa == `LCDRF_BUF_LAST)
        d.fetch_done = 1'b1;
      else
        d.fa = q.fa + 16'h0001;
    end

    // panel sequencer runs with no software help once enabled
    if (!q.en && (q.st != lcdrf_pkg::ST_IDLE))
    begin
      // Disable drops the dot clock, line pulse, marker and data lines at once; ac keeps its level
      d.st   = lcdrf_pkg::ST_IDLE;
      d.dot  = 1'b0;
      d.lp   = 1'b0;
      d.fp   = 1'b0;
      d.data = 4'h0;
    end
    else
    begin
      unique case (q.st)
        lcdrf_pkg::ST_IDLE:
        begin
          if (q.en)
          begin
            // frame fetch begins at the start address
            d.fa         = q.start;
            d.fetch_done = 1'b0;
            d.flush      = 1'b1;
            d.sh_cnt     = 5'h00;
            d.nib_k      = 2'h0;
            d.px         = 9'h000;
            d.line       = 8'h00;
            d.st         = lcdrf_pkg::ST_GATHER;
          end
        end
        lcdrf_pkg::ST_GATHER:
        begin
          // Collect the pixels of one dot, one per aclk cycle
          if (q.sh_cnt == 5'h00)
          begin
            // Hold off while the flush clears words left from the last frame
            fifo_out_ready = !q.flush;
            if (fifo_out_valid && !q.flush)
            begin
              d.sh     = fifo_out_data;
              // a grey word holds eight pixels
              d.sh_cnt = q.grey ? `LCDRF_PX_GREY : `LCDRF_PX_BW;
            end
          end
          else
          begin
            d.nib[q.nib_k] = pix_on;
            d.sh           = q.grey ? (q.sh >> 2) : (q.sh >> 1);
            d.sh_cnt       = q.sh_cnt - 5'h01;
            if (q.nib_k == ppd_last)
            begin
              d.nib_k = 2'h0;
              d.st    = lcdrf_pkg::ST_HOLD;
            end
            else
              d.nib_k = q.nib_k + 2'h1;
          end
        end
        lcdrf_pkg::ST_HOLD:
        begin
          // four lines in four-bit mode, else line 0 only
          if (tick)
          begin
            d.data = q.four_bit ? q.nib : {3'b000, q.nib[0]};
            d.st   = lcdrf_pkg::ST_RISE;
          end
        end
        lcdrf_pkg::ST_RISE:
        begin
          // dot clock rises one LCD clock after the data settle
          if (tick)
          begin
            d.dot = 1'b1;
            d.st  = lcdrf_pkg::ST_FALL;
          end
        end
        lcdrf_pkg::ST_FALL:
        begin
          if (tick)
          begin
            d.dot = 1'b0;
            d.px  = q.px + {7'h00, ppd_last} + 9'h001;
            // nine-bit segment count spans a 240-dot line
            if ((q.px + {7'h00, ppd_last} + 9'h001) >= q.segs)
              d.st = lcdrf_pkg::ST_LINE;
            else
              d.st = lcdrf_pkg::ST_GATHER;
          end
        end
        lcdrf_pkg::ST_LINE:
        begin
          // line pulse after the line, marker with line 0
          if (tick)
          begin
            d.lp = 1'b1;
            d.fp = (q.line == 8'h00);
            d.st = lcdrf_pkg::ST_LINE_END;
          end
        end
        lcdrf_pkg::ST_LINE_END:
        begin
          if (tick)
          begin
            d.lp = 1'b0;
            d.fp = 1'b0;
            d.px = 9'h000;
            d.st = lcdrf_pkg::ST_GATHER;
            if ((q.line + 8'h01) >= q.coms)
            begin
              d.ac         = !q.ac;
              d.frm        = (q.frm == `LCDRF_FRM_LAST) ? 2'h0 : q.frm + 2'h1;
              d.frames     = q.frames + 16'h0001;
              d.line       = 8'h00;
              // each frame refetches from the start address
              d.fa         = q.start;
              d.fetch_done = 1'b0;
              d.flush      = 1'b1;
              d.sh_cnt     = 5'h00;
            end
            else
              d.line = q.line + 8'h01;
          end
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q         <= '0;
      q.st      <= lcdrf_pkg::ST_IDLE;
      q.start   <= `LCDRF_START_RST;
      q.segs    <= `LCDRF_SEGS_RST;
      q.coms    <= `LCDRF_COMS_RST;
      q.fa      <= `LCDRF_BUF_FIRST;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end
    else
      q <= d;
  end

  // display buffer written only through the bus window
  always_ff @(posedge aclk)
  begin
    if (mem_we)
      buf_mem[mem_idx] <= mem_wd;
  end
endmodule
`default_nettype wire

// ==== src/lcdrf_consts.svh ====
// Register offsets, field positions, reset values and limits of the LCD refresh engine
`ifndef LCDRF_CONSTS_SVH
`define LCDRF_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define LCDRF_CTRL_OFF      18'h00000
`define LCDRF_START_OFF     18'h00004
`define LCDRF_SEGS_OFF      18'h00008
`define LCDRF_COMS_OFF      18'h0000c
`define LCDRF_STATUS_OFF    18'h00010
// Display buffer window: byte address = word address * 4
`define LCDRF_BUF_SEL       4'hb
// Control field positions
`define LCDRF_CTRL_EN       0
`define LCDRF_CTRL_FOUR     1
`define LCDRF_CTRL_GREY     2
`define LCDRF_CTRL_PINS     3
// Reset values
`define LCDRF_START_RST     16'hb000
`define LCDRF_SEGS_RST      9'h0f0
`define LCDRF_COMS_RST      8'h78
// Display buffer word range
`define LCDRF_BUF_FIRST     16'hb000
`define LCDRF_BUF_LAST      16'hbfff
// Pixels per buffer word, and pixels per dot-clock cycle minus one
`define LCDRF_PX_BW         5'h10
`define LCDRF_PX_GREY       5'h08
`define LCDRF_PPD_ONE       2'h0
`define LCDRF_PPD_FOUR      2'h3
// Last frame phase of the three-frame modulation period
`define LCDRF_FRM_LAST      2'h2
// AXI responses
`define LCDRF_RESP_OKAY     2'h0
`define LCDRF_RESP_SLVERR   2'h2

`endif

// ==== src/lcdrf_pkg.sv ====
// Types shared by the LCD refresh engine
package lcdrf_pkg;

  // Refresh sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GATHER,
    ST_HOLD,
    ST_RISE,
    ST_FALL,
    ST_LINE,
    ST_LINE_END
  } lcdrf_state_t;

  // Complete state of the top module
  typedef struct packed {
    logic [2:0]   sync;        // LCD clock synchroniser
    logic         dot_clock_out_stable; // Last agreed LCD clock level
    lcdrf_state_t st;
    logic         en;
    logic         four_bit;
    logic         grey;
    logic         pin_sel;
    logic [15:0]  start;
    logic [8:0]   segs;
    logic [7:0]   coms;
    logic [15:0]  fa;          // Fetch word address
    logic         fetch_done;
    logic         flush;
    logic [15:0]  sh;          // Pixel shifter
    logic [4:0]   sh_cnt;
    logic [3:0]   nib;
    logic [1:0]   nib_k;
    logic [8:0]   px;
    logic [7:0]   line;
    logic [1:0]   frm;
    logic [15:0]  frames;
    logic         ac;
    logic         dot;
    logic         lp;
    logic         fp;
    logic [3:0]   data;
    logic         aw_held;
    logic [17:0]  awaddr;
    logic         w_held;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } lcdrf_regs_t;

endpackage

// ==== src/lcdrf_fifo.sv ====
// Word FIFO between the buffer fetch and the pixel shifter
`timescale 1ns/100ps
`default_nettype none
module lcdrf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers carry one wrap bit to tell full from empty
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lcdrf_fifo_t;

  lcdrf_fifo_t      q;          // Registered pointers
  lcdrf_fifo_t      d;          // Next pointers
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic             full;
  logic             empty;

  assign empty     = (q.wp == q.rp);
  assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[q.rp[AW-1:0]];

  // Pointer update; flush drops whatever is left
  always_comb
  begin
    d = q;
    if (flush)
    begin
      d.wp = '0;
      d.rp = '0;
    end
    else
    begin
      if (in_valid && !full)
        d.wp = q.wp + 1'b1;
      if (out_ready && !empty)
        d.rp = q.rp + 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  // Storage write, no reset needed on data
  always_ff @(posedge aclk)
  begin
    if (in_valid && !full && !flush)
      mem[q.wp[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ==== test/lcdrf_panel_model.sv ====
// Receiving panel driver model: reports every dot and line pulse it sees
`timescale 1ns/100ps
`default_nettype none
module lcdrf_panel_model (
  input  wire logic       aclk,
  input  wire logic       dot_clock_out,
  input  wire logic       line_pulse_out,
  input  wire logic       first_line_marker_out,
  input  wire logic [3:0] panel_data_out,
  output logic            ev,
  output logic [4:0]      ev_word
);
  logic dot_q = 1'b0; // Last dot clock level
  logic lp_q  = 1'b0; // Last line pulse level
  // Sample on rising edges only, as a real driver latches on its clock edge
  always_ff @(posedge aclk)
  begin
    dot_q <= dot_clock_out;
    lp_q  <= line_pulse_out;
    ev    <= 1'b0;
    if (dot_clock_out && !dot_q)
    begin
      ev      <= 1'b1;
      ev_word <= {1'b0, panel_data_out};
    end
    else if (line_pulse_out && !lp_q)
    begin
      ev      <= 1'b1;
      ev_word <= {1'b1, 3'h0, first_line_marker_out};
    end
  end
endmodule
`default_nettype wire

// ==== test/lcdrf_top_assertions.sv ====
// Concurrent checks on the ports of the LCD refresh engine
`timescale 1ns/100ps
`default_nettype none
module lcdrf_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        ac_alternate_out,
  input wire logic        dot_clock_out,
  input wire logic        line_pulse_out,
  input wire logic        first_line_marker_out,
  input wire logic [3:0]  panel_data_out
);
  // One LCD period is 16 aclk; synchroniser jitter allows a cycle either way
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_dot_high_width: assert property (
    $rose(dot_clock_out) |-> dot_clock_out[*8] ##[1:12] !dot_clock_out)
    else $error("dot clock high time wrong");
  a_dot_low_gap: assert property (
    $fell(dot_clock_out) |-> !dot_clock_out[*8])
    else $error("dot clock low time too short");
  a_data_under_dot: assert property (
    dot_clock_out |-> $stable(panel_data_out))
    else $error("panel data moved while dot clock high");
  a_lp_no_dot: assert property (
    line_pulse_out |-> !dot_clock_out)
    else $error("line pulse overlaps dot clock");
  a_lp_width: assert property (
    $rose(line_pulse_out) |-> line_pulse_out[*8] ##[1:12] !line_pulse_out)
    else $error("line pulse width wrong");
  a_marker_in_lp: assert property (
    first_line_marker_out |-> line_pulse_out)
    else $error("marker outside line pulse");
  a_ac_between_dots: assert property (
    $changed(ac_alternate_out) |-> !dot_clock_out)
    else $error("alternation moved during a dot");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_wr_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind lcdrf_top lcdrf_checker i_lcdrf_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .ac_alternate_out(ac_alternate_out),
  .dot_clock_out(dot_clock_out), .line_pulse_out(line_pulse_out),
  .first_line_marker_out(first_line_marker_out), .panel_data_out(panel_data_out));
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the LCD refresh engine
`timescale 1ns/100ps
`default_nettype none
`include "lcdrf_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic        aclk, aresetn, lcd_clk_src, awvalid, wvalid, bready, arvalid, rready;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, ac, dot, lp, fp, pin_sel;
  logic [1:0]  bresp, rresp;
  logic [3:0]  pd, wstrb;
  logic        ev, last_ac;
  logic [4:0]  ev_word;
  int          failures, samples_checked, seed, frames_seen, frm_base;
  logic [33:0] rq[$]; // Expected read answers
  logic [1:0]  bq[$]; // Expected write answers
  logic [4:0]  pq[$]; // Expected dots and line pulses
  // System clock, 100 MHz
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Free-running LCD clock, phase unrelated to aclk
  initial
  begin
    lcd_clk_src = 1'b0;
    #3.3;
    forever #80 lcd_clk_src = ~lcd_clk_src;
  end
  lcdrf_top i_lcdrf_top (.aclk(aclk), .aresetn(aresetn), .lcd_clk_src(lcd_clk_src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ac_alternate_out(ac), .dot_clock_out(dot), .line_pulse_out(lp),
    .first_line_marker_out(fp), .panel_data_out(pd), .lcd_pin_select(pin_sel));
  lcdrf_panel_model i_lcdrf_panel_model (.aclk(aclk), .dot_clock_out(dot),
    .line_pulse_out(lp), .first_line_marker_out(fp), .panel_data_out(pd),
    .ev(ev), .ev_word(ev_word));
  // Watcher: every answer or panel event takes the oldest note off its queue
  always @(posedge aclk)
  begin
    if (bvalid && bready) `CHK(bresp, bq.pop_front())
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    if (ev) `CHK(ev_word, pq.pop_front())
    if (ev && ev_word[4] && ev_word[0])
    begin
      if (frames_seen > 0) `CHK(ac, ~last_ac)
      last_ac = ac;
      frames_seen++;
    end
  end
  task automatic results();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Write; bready is raised only once bvalid shows, so the hold is exercised
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= !bready;
    end while (!(bvalid && bready) && n < 100);
    if (n >= 100) begin failures++; results(); end
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= !rready;
    end while (!(rvalid && rready) && n < 100);
    if (n >= 100) begin failures++; results(); end
  endtask
  // Fill a 16x2 frame, enable, expect two frames of dots and line pulses
  task automatic panel_run(input logic grey, input logic four);
    logic [31:0] r;
    logic [63:0] raw;
    logic [15:0] st, on;
    logic [1:0]  lv;
    int          k, i, n, nw;
    nw = grey ? 4 : 2;
    st = 16'hc000 - 16'(nw);
    for (k = 0; k < nw; k++)
    begin
      r = $random(seed);
      raw[16*k +: 16] = r[15:0];
      wr({st + 16'(k), 2'b00}, r, `LCDRF_RESP_OKAY);
    end
    wr(`LCDRF_SEGS_OFF, 32'h10, `LCDRF_RESP_OKAY);
    wr(`LCDRF_COMS_OFF, 32'h2, `LCDRF_RESP_OKAY);
    wr(`LCDRF_START_OFF, {16'h0, st}, `LCDRF_RESP_OKAY);
    // Shade phase of frame n is the running frame count modulo three
    for (n = 0; n < 2; n++)
      for (k = 0; k < 2; k++)
      begin
        for (i = 0; i < 16; i++)
        begin
          lv    = grey ? raw[32*k + 2*i +: 2] : {2{raw[16*k + i]}};
          on[i] = (lv == 2'h3) || (lv == 2'h2 && (frm_base + n) % 3 != 2)
                  || (lv == 2'h1 && (frm_base + n) % 3 == 0);
        end
        for (i = 0; i < (four ? 4 : 16); i++)
          pq.push_back({1'b0, four ? on[4*i +: 4] : {3'h0, on[i]}});
        pq.push_back({1'b1, 3'h0, k == 0});
      end
    frames_seen = 0;
    wr(`LCDRF_CTRL_OFF, {28'h0, 1'b1, grey, four, 1'b1}, `LCDRF_RESP_OKAY);
    `CHK(pin_sel, 1'b1)
    for (n = 0; n < 20000 && pq.size() > 0; n++) @(posedge aclk);
    if (pq.size() > 0) begin failures++; results(); end
    // Disable cuts a running pulse short, so let the last line pulse end first
    repeat (24) @(posedge aclk);
    wr(`LCDRF_CTRL_OFF, 32'h0, `LCDRF_RESP_OKAY);
    `CHK(frames_seen, 2)
    frm_base += 2;
    rd(`LCDRF_STATUS_OFF, {16'(frm_base), 16'h0000}, `LCDRF_RESP_OKAY);
  endtask
  // Main sequence
  initial
  begin
    seed = 32'hec713d9a;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    frm_base = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LCDRF_CTRL_OFF, 32'h0, `LCDRF_RESP_OKAY);
    rd(`LCDRF_START_OFF, 32'hb000, `LCDRF_RESP_OKAY);
    rd(`LCDRF_SEGS_OFF, 32'hf0, `LCDRF_RESP_OKAY);
    rd(`LCDRF_COMS_OFF, 32'h78, `LCDRF_RESP_OKAY);
    // Just below the buffer window is unmapped
    wr(18'h2bffc, 32'h1, `LCDRF_RESP_SLVERR);
    rd(18'h2bffc, 32'h0, `LCDRF_RESP_SLVERR);
    // Buffer keeps only the low half of a word
    seed = $random(seed);
    wr(18'h2c000, seed, `LCDRF_RESP_OKAY);
    rd(18'h2c000, {16'h0, seed[15:0]}, `LCDRF_RESP_OKAY);
    // Only the strobed byte lane of a buffer word changes
    wstrb <= 4'h1;
    wr(18'h2c000, 32'h0000a55a, `LCDRF_RESP_OKAY);
    wstrb <= 4'hf;
    rd(18'h2c000, {16'h0, seed[15:8], 8'h5a}, `LCDRF_RESP_OKAY);
    panel_run(1'b0, 1'b0);
    panel_run(1'b1, 1'b1);
    repeat (4) @(posedge aclk);
    results();
  end
endmodule
`default_nettype wire
